// file: atcp_map.svh
`ifndef ATCP_MAP_SVH
`define ATCP_MAP_SVH
`define ATCP_ADR_CTRL 8'h00
`define ATCP_ADR_FUNC 8'h04
`define ATCP_ADR_VGAIN 8'h08
`define ATCP_ADR_TGAIN 8'h0c
`define ATCP_ADR_OFS1 8'h10
`define ATCP_ADR_OFS2 8'h14
`define ATCP_ADR_OFSD 8'h18
`define ATCP_ADR_DB1 8'h1c
`define ATCP_ADR_DB2 8'h20
`define ATCP_ADR_DBD 8'h24
`define ATCP_ADR_FILT 8'h28
`define ATCP_ADR_VEL 8'h2c
`define ATCP_ADR_TRQ 8'h30
`define ATCP_ADR_STAT 8'h34
`define ATCP_CTRL_TYPE_BIT 0
`define ATCP_CTRL_AZ_BIT 1
`define ATCP_CTRL_MAIN_LSB 8
`define ATCP_CTRL_SEC_LSB 16
`define ATCP_FUNC_SECOND_LSB 8
`define ATCP_RST_MAIN 5'h07
`define ATCP_RST_SEC 5'h15
`define ATCP_RST_FUNC 2'h3
`define ATCP_RST_VGAIN 8'h14
`define ATCP_RST_TGAIN 12'h064
`define ATCP_RST_FILT 14'h01f4
`define ATCP_VGAIN_MAX 8'h64
`define ATCP_TGAIN_MAX 12'h7d0
`define ATCP_OFS_MAX 16'h6aa4
`define ATCP_FILT_MAX 14'h3e76
`define ATCP_OFS_TO_CODE 17'h0_4cd2
`define ATCP_CODE_TO_DISP 16'h3555
`define ATCP_MV_TO_CODE 16'h346e
`define ATCP_ALPHA_PER_HZ 8'h0d
`define ATCP_MODE_TRQ_FREE 5'h02
`define ATCP_MODE_TRQ_RUN 5'h05
`endif

// file: atcp_pkg.sv
package atcp_pkg;
  typedef enum logic [0:0] {
    AZ_IDLE = 1'b0,
    AZ_WAIT = 1'b1
  } atcp_az_e;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic in_type;
    logic [4:0] main_mode;
    logic [4:0] sec_mode;
    logic [1:0] func1;
    logic [1:0] func2;
    logic signed [7:0] vgain;
    logic signed [11:0] tgain;
    logic signed [15:0] ofs1;
    logic signed [15:0] ofs2;
    logic signed [15:0] ofsd;
    logic [7:0] db1;
    logic [7:0] db2;
    logic [7:0] dbd;
    logic [13:0] filt;
    atcp_az_e az;
    logic [2:0] x1_sync;
    logic x1;
    logic signed [29:0] yv;
    logic signed [29:0] yt;
    logic signed [21:0] vel_cmd;
    logic signed [25:0] trq_cmd;
    logic cmd_valid;
    logic run_en;
  } atcp_state_s;
endpackage : atcp_pkg

// file: atcp_command_path.sv
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "atcp_map.svh"
module atcp_command_path #(
  parameter logic [7:0] ALPHA_PER_HZ = `ATCP_ALPHA_PER_HZ
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [11:0] adc_first_i,
  input wire logic [11:0] adc_second_i,
  input wire logic adc_valid_i,
  input wire logic digital_in_one_i,
  output logic signed [21:0] velocity_cmd_o,
  output logic signed [25:0] torque_cmd_o,
  output logic cmd_valid_o,
  output logic run_enable_o,
  output logic [4:0] main_control_select_o,
  output logic [4:0] secondary_control_select_o
);

  if (ALPHA_PER_HZ == 8'h00) begin : g_bad_alpha
    $error("The filter coefficient per hertz must not be zero.");
  end

  localparam logic signed [15:0] OFS_MAX = `ATCP_OFS_MAX;
  localparam logic signed [11:0] TGAIN_MAX = `ATCP_TGAIN_MAX;
  localparam logic signed [7:0] VGAIN_MAX = `ATCP_VGAIN_MAX;

  localparam atcp_pkg::atcp_state_s ST_RST = '{
    main_mode: `ATCP_RST_MAIN,
    sec_mode: `ATCP_RST_SEC,
    func1: `ATCP_RST_FUNC,
    func2: `ATCP_RST_FUNC,
    vgain: `ATCP_RST_VGAIN,
    tgain: `ATCP_RST_TGAIN,
    filt: `ATCP_RST_FILT,
    az: atcp_pkg::AZ_IDLE,
    default: '0
  };

  atcp_pkg::atcp_state_s st_q;
  atcp_pkg::atcp_state_s st_d;

  function automatic logic mode_ok(input logic [4:0] m);
    return (m >= 5'h01 && m <= 5'h08) || (m >= 5'h0a && m <= 5'h12) || m == 5'h15 || m == 5'h16;
  endfunction : mode_ok

  // Display units of volts times 2730 turn into converter codes of 2048 per 10 V.
  function automatic logic signed [13:0] ofs_code(input logic signed [15:0] disp);
    logic signed [32:0] p;
    p = disp * $signed(`ATCP_OFS_TO_CODE);
    return p[31:18];
  endfunction : ofs_code

  function automatic logic [13:0] db_code(input logic [7:0] mv);
    logic [23:0] p;
    p = mv * `ATCP_MV_TO_CODE;
    return {8'h00, p[21:16]};
  endfunction : db_code

  function automatic logic signed [13:0] dead(input logic signed [13:0] v, input logic [13:0] th);
    logic [13:0] mag;
    mag = v[13] ? 14'(-v) : v;
    return (mag <= th) ? 14'sh0000 : v;
  endfunction : dead

  // Captured bias back to display units, clamped to the legal offset span.
  function automatic logic signed [15:0] to_disp(input logic signed [13:0] c);
    logic signed [30:0] p;
    logic signed [30:0] q;
    p = c * $signed({1'b0, `ATCP_CODE_TO_DISP});
    q = p >>> 10;
    if (q > 31'(OFS_MAX)) begin
      return OFS_MAX;
    end else if (q < -31'(OFS_MAX)) begin
      return -OFS_MAX;
    end
    return q[15:0];
  endfunction : to_disp

  // First-order low-pass; the state carries 16 fraction bits so slow corners do not stall.
  function automatic logic signed [29:0] lp(input logic signed [29:0] y, input logic signed [13:0] x,
                                             input logic [15:0] a);
    logic signed [30:0] diff;
    logic signed [47:0] prod;
    logic signed [47:0] step;
    diff = 31'($signed({x, 16'h0000})) - 31'(y);
    prod = diff * $signed({1'b0, a});
    step = prod >>> 16;
    return y + step[29:0];
  endfunction : lp

  // Rounding the output keeps the small negative residue of the floored filter from showing as one code.
  function automatic logic signed [13:0] rnd(input logic signed [29:0] y);
    logic signed [29:0] r;
    r = y + 30'sh0000_8000;
    return r[29:16];
  endfunction : rnd

  logic [7:0] adr;
  logic [31:0] cur;
  logic [31:0] wv;
  logic signed [13:0] s1;
  logic signed [13:0] s2;
  logic signed [13:0] c1;
  logic signed [13:0] c2;
  logic signed [13:0] cd;
  logic signed [13:0] vx;
  logic signed [13:0] tx;
  logic [21:0] ap;
  logic [15:0] alpha;

  always_comb begin
    st_d = st_q;
    st_d.cmd_valid = 1'b0;
    adr = {wb_adr_i[7:2], 2'b00};

    // Current word at the address, used for reads and for byte-lane merging.
    cur = 32'h0000_0000;
    case (adr)
      `ATCP_ADR_CTRL: begin
        cur[`ATCP_CTRL_TYPE_BIT] = st_q.in_type;
        cur[`ATCP_CTRL_AZ_BIT] = (st_q.az == atcp_pkg::AZ_WAIT);
        cur[`ATCP_CTRL_MAIN_LSB +: 5] = st_q.main_mode;
        cur[`ATCP_CTRL_SEC_LSB +: 5] = st_q.sec_mode;
      end
      `ATCP_ADR_FUNC: begin
        cur[1:0] = st_q.func1;
        cur[`ATCP_FUNC_SECOND_LSB +: 2] = st_q.func2;
      end
      `ATCP_ADR_VGAIN: cur = 32'($signed(st_q.vgain));
      `ATCP_ADR_TGAIN: cur = 32'($signed(st_q.tgain));
      `ATCP_ADR_OFS1: cur = 32'($signed(st_q.ofs1));
      `ATCP_ADR_OFS2: cur = 32'($signed(st_q.ofs2));
      `ATCP_ADR_OFSD: cur = 32'($signed(st_q.ofsd));
      `ATCP_ADR_DB1: cur[7:0] = st_q.db1;
      `ATCP_ADR_DB2: cur[7:0] = st_q.db2;
      `ATCP_ADR_DBD: cur[7:0] = st_q.dbd;
      `ATCP_ADR_FILT: cur[13:0] = st_q.filt;
      `ATCP_ADR_VEL: cur = 32'($signed(st_q.vel_cmd));
      `ATCP_ADR_TRQ: cur = 32'($signed(st_q.trq_cmd));
      `ATCP_ADR_STAT: cur[1:0] = {st_q.x1, st_q.run_en};
      default: cur = 32'h0000_0000;
    endcase
    for (int b = 0; b < 4; b++) begin
      wv[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : cur[8*b +: 8];
    end

    // One wait state: ack rises the cycle after the strobe and drops for a cycle.
    st_d.ack = wb_cyc_i & wb_stb_i & ~st_q.ack;
    if (st_d.ack) begin
      st_d.rdata = cur;
    end

    // Out-of-range settings are refused and the old value stays.
    if (st_d.ack && wb_we_i) begin
      case (adr)
        `ATCP_ADR_CTRL: begin
          st_d.in_type = wv[`ATCP_CTRL_TYPE_BIT];
          if (wv[`ATCP_CTRL_AZ_BIT]) begin
            st_d.az = atcp_pkg::AZ_WAIT;
          end
          if (mode_ok(wv[`ATCP_CTRL_MAIN_LSB +: 5])) begin
            st_d.main_mode = wv[`ATCP_CTRL_MAIN_LSB +: 5];
          end
          if (mode_ok(wv[`ATCP_CTRL_SEC_LSB +: 5])) begin
            st_d.sec_mode = wv[`ATCP_CTRL_SEC_LSB +: 5];
          end
        end
        `ATCP_ADR_FUNC: begin
          if (wv[1:0] != 2'h0) begin
            st_d.func1 = wv[1:0];
          end
          if (wv[`ATCP_FUNC_SECOND_LSB +: 2] != 2'h0) begin
            st_d.func2 = wv[`ATCP_FUNC_SECOND_LSB +: 2];
          end
        end
        `ATCP_ADR_VGAIN: begin
          if ($signed(wv) <= 32'(VGAIN_MAX) && $signed(wv) >= -32'(VGAIN_MAX)) begin
            st_d.vgain = wv[7:0];
          end
        end
        `ATCP_ADR_TGAIN: begin
          if ($signed(wv) <= 32'(TGAIN_MAX) && $signed(wv) >= -32'(TGAIN_MAX)) begin
            st_d.tgain = wv[11:0];
          end
        end
        `ATCP_ADR_OFS1: begin
          if ($signed(wv) <= 32'(OFS_MAX) && $signed(wv) >= -32'(OFS_MAX)) begin
            st_d.ofs1 = wv[15:0];
          end
        end
        `ATCP_ADR_OFS2: begin
          if ($signed(wv) <= 32'(OFS_MAX) && $signed(wv) >= -32'(OFS_MAX)) begin
            st_d.ofs2 = wv[15:0];
          end
        end
        `ATCP_ADR_OFSD: begin
          if ($signed(wv) <= 32'(OFS_MAX) && $signed(wv) >= -32'(OFS_MAX)) begin
            st_d.ofsd = wv[15:0];
          end
        end
        `ATCP_ADR_DB1: begin
          if (wv[31:8] == 24'h00_0000) begin
            st_d.db1 = wv[7:0];
          end
        end
        `ATCP_ADR_DB2: begin
          if (wv[31:8] == 24'h00_0000) begin
            st_d.db2 = wv[7:0];
          end
        end
        `ATCP_ADR_DBD: begin
          if (wv[31:8] == 24'h00_0000) begin
            st_d.dbd = wv[7:0];
          end
        end
        `ATCP_ADR_FILT: begin
          if (wv != 32'h0000_0000 && wv <= 32'(`ATCP_FILT_MAX)) begin
            st_d.filt = wv[13:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Digital input: three stages, a change counts once stages two and three agree.
    st_d.x1_sync = {st_q.x1_sync[1:0], digital_in_one_i};
    if (st_q.x1_sync[1] == st_q.x1_sync[2]) begin
      st_d.x1 = st_q.x1_sync[2];
    end
    st_d.run_en = (st_q.main_mode == `ATCP_MODE_TRQ_FREE) ||
                  (st_q.main_mode == `ATCP_MODE_TRQ_RUN && st_q.x1);

    // Offset-binary converter codes become signed codes of 2048 per 10 V.
    s1 = 14'($signed({~adc_first_i[11], adc_first_i[10:0]}));
    s2 = 14'($signed({~adc_second_i[11], adc_second_i[10:0]}));
    c1 = dead(s1 - ofs_code(st_q.ofs1), db_code(st_q.db1));
    c2 = dead(s2 - ofs_code(st_q.ofs2), db_code(st_q.db2));
    cd = dead((s1 - s2) - ofs_code(st_q.ofsd), db_code(st_q.dbd));

    if (st_q.in_type) begin
      vx = cd;
      tx = cd;
    end else begin
      // Setting 3 keeps the native role of each input; 1 routes to velocity, 2 to torque.
      vx = (st_q.func1 == 2'h1 || st_q.func1 == 2'h3) ? c1 :
           (st_q.func2 == 2'h1) ? c2 : 14'sh0000;
      tx = (st_q.func2 == 2'h2 || st_q.func2 == 2'h3) ? c2 :
           (st_q.func1 == 2'h2) ? c1 : 14'sh0000;
    end

    // Corners far above the sample rate saturate to a pass-through.
    ap = st_q.filt * ALPHA_PER_HZ;
    alpha = (ap[21:16] != 6'h00) ? 16'hffff : ap[15:0];

    if (adc_valid_i) begin
      st_d.yv = lp(st_q.yv, vx, alpha);
      st_d.yt = lp(st_q.yt, tx, alpha);
      st_d.vel_cmd = rnd(st_d.yv) * st_q.vgain;
      st_d.trq_cmd = rnd(st_d.yt) * st_q.tgain;
      st_d.cmd_valid = 1'b1;
      // A single raw sample is taken as the bias, so the host must hold zero volts meanwhile.
      if (st_q.az == atcp_pkg::AZ_WAIT) begin
        st_d.ofs1 = to_disp(s1);
        st_d.ofs2 = to_disp(s2);
        st_d.ofsd = to_disp(s1 - s2);
        st_d.az = atcp_pkg::AZ_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o = st_q.rdata;
  assign wb_ack_o = st_q.ack;
  assign velocity_cmd_o = st_q.vel_cmd;
  assign torque_cmd_o = st_q.trq_cmd;
  assign cmd_valid_o = st_q.cmd_valid;
  assign run_enable_o = st_q.run_en;
  assign main_control_select_o = st_q.main_mode;
  assign secondary_control_select_o = st_q.sec_mode;

endmodule : atcp_command_path

// file: atcp_command_path_sva.sv
`timescale 1ns/1ps
module atcp_command_path_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic adc_valid_i,
  input wire logic digital_in_one_i,
  input wire logic signed [21:0] velocity_cmd_o,
  input wire logic signed [25:0] torque_cmd_o,
  input wire logic cmd_valid_o,
  input wire logic run_enable_o,
  input wire logic [4:0] main_control_select_o,
  input wire logic [4:0] secondary_control_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ack_due;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_due: assert property (p_ack_due) else $error("request not acknowledged");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_valid_due;
    adc_valid_i |=> cmd_valid_o;
  endproperty
  a_valid_due: assert property (p_valid_due) else $error("sample not answered");
  property p_valid_cause;
    cmd_valid_o |-> $past(adc_valid_i);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("valid without sample");
  // The reset guard keeps a pre-reset value out of the comparison.
  property p_out_hold;
    $past(rst_n_i) && !cmd_valid_o |-> $stable(velocity_cmd_o) && $stable(torque_cmd_o);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("command moved without sample");
  property p_modes_legal;
    main_control_select_o inside {[5'h01:5'h08], [5'h0a:5'h12], 5'h15, 5'h16} &&
    secondary_control_select_o inside {[5'h01:5'h08], [5'h0a:5'h12], 5'h15, 5'h16};
  endproperty
  a_modes_legal: assert property (p_modes_legal) else $error("illegal mode held");
  property p_run_free;
    (main_control_select_o == 5'h02) [*2] |-> run_enable_o;
  endproperty
  a_run_free: assert property (p_run_free) else $error("free mode not running");
  property p_run_off;
    (main_control_select_o != 5'h02 && main_control_select_o != 5'h05) [*2] |-> !run_enable_o;
  endproperty
  a_run_off: assert property (p_run_off) else $error("run in other mode");
  property p_run_gated;
    (main_control_select_o == 5'h05 && !digital_in_one_i) [*6] |-> !run_enable_o;
  endproperty
  a_run_gated: assert property (p_run_gated) else $error("run while pin low");
endmodule : atcp_command_path_sva
bind atcp_command_path atcp_command_path_sva atcp_command_path_sva_i (.clk_i, .rst_n_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .adc_valid_i, .digital_in_one_i, .velocity_cmd_o, .torque_cmd_o, .cmd_valid_o,
  .run_enable_o, .main_control_select_o, .secondary_control_select_o);

// file: atcp_host_model.sv
`timescale 1ns/1ps
module atcp_host_model (
  input wire logic clk_i,
  input wire logic [3:0] gap_i,
  input wire logic [11:0] first_i,
  input wire logic [11:0] second_i,
  output logic [11:0] adc_first_o,
  output logic [11:0] adc_second_o,
  output logic adc_valid_o
);
  logic [3:0] wait_q;
  initial begin
    wait_q = 4'h0;
    adc_valid_o = 1'b0;
    adc_first_o = 12'h800;
    adc_second_o = 12'h800;
  end
  // Between strobes the lines flip, so a stale read shows up as a wrong command.
  always @(posedge clk_i) begin
    if (wait_q == 4'h0) begin
      wait_q <= gap_i;
      adc_valid_o <= 1'b1;
      adc_first_o <= first_i;
      adc_second_o <= second_i;
    end else begin
      wait_q <= wait_q - 4'h1;
      adc_valid_o <= 1'b0;
      adc_first_o <= ~adc_first_o;
      adc_second_o <= ~adc_second_o;
    end
  end
endmodule : atcp_host_model

// file: testbench.sv
`timescale 1ns/1ps
`include "atcp_map.svh"
module testbench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [11:0] adc_first_i;
  logic [11:0] adc_second_i;
  logic adc_valid_i;
  logic digital_in_one_i = 1'b0;
  logic signed [21:0] velocity_cmd_o;
  logic signed [25:0] torque_cmd_o;
  logic cmd_valid_o;
  logic run_enable_o;
  logic [4:0] main_control_select_o;
  logic [4:0] secondary_control_select_o;
  logic [3:0] gap = 4'h0;
  logic jit = 1'b1;
  logic [11:0] lvl1 = 12'h800;
  logic [11:0] lvl2 = 12'h800;
  logic [15:0] lfsr_q = 16'h005f;
  logic [31:0] rd;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  wire logic [11:0] f1 = jit ? lvl1 + {6'h00, lfsr_q[5:0]} - 12'h020 : lvl1;
  wire logic [11:0] f2 = jit ? lvl2 + {6'h00, lfsr_q[11:6]} - 12'h020 : lvl2;
  initial forever #25 clk_i = ~clk_i;
  atcp_command_path atcp_command_path_i (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .adc_first_i, .adc_second_i, .adc_valid_i,
    .digital_in_one_i, .velocity_cmd_o, .torque_cmd_o, .cmd_valid_o, .run_enable_o,
    .main_control_select_o, .secondary_control_select_o);
  atcp_host_model atcp_host_model_i (.clk_i, .gap_i(gap), .first_i(f1), .second_i(f2),
    .adc_first_o(adc_first_i), .adc_second_o(adc_second_i), .adc_valid_o(adc_valid_i));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  function automatic logic [31:0] ctrl_w(input logic [4:0] m, input logic [4:0] s, input logic t);
    return {11'h000, s, 3'h0, m, 7'h00, t};
  endfunction : ctrl_w
  function automatic logic [31:0] ofs_c(input logic [31:0] c);
    return (c * 32'h0000_3555) >> 10;
  endfunction : ofs_c
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 16) mismatches++;
    @(posedge clk_i);
  endtask : wb
  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    if (we) wb(1'b1, a, d);
    wb(1'b0, a, 32'h0000_0000);
    check($sformatf("reg %h", a), rd, e);
  endtask : acc
  task automatic sig(input string n, input logic v, input logic e);
    check(n, {31'h0000_0000, v}, {31'h0000_0000, e});
  endtask : sig
  always @(posedge clk_i) begin
    lfsr_q <= lfsr_next(lfsr_q);
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    check("main sel", 32'(main_control_select_o), 32'h0000_0007);
    check("sec sel", 32'(secondary_control_select_o), 32'h0000_0015);
    acc(1'b0, `ATCP_ADR_CTRL, 0, ctrl_w(5'h07, 5'h15, 1'b0));
    acc(1'b0, `ATCP_ADR_FUNC, 0, 32'h0000_0303);
    acc(1'b0, `ATCP_ADR_VGAIN, 0, 32'h0000_0014);
    acc(1'b0, `ATCP_ADR_TGAIN, 0, 32'h0000_0064);
    for (int i = 0; i < 6; i++) acc(1'b0, `ATCP_ADR_OFS1 + 8'(4 * i), 0, 0);
    acc(1'b0, `ATCP_ADR_FILT, 0, 32'h0000_01f4);
    acc(1'b0, 8'h3c, 0, 0);
    acc(1'b1, `ATCP_ADR_CTRL, ctrl_w(5'h09, 5'h15, 1'b0), ctrl_w(5'h07, 5'h15, 1'b0));
    acc(1'b1, `ATCP_ADR_CTRL, ctrl_w(5'h16, 5'h01, 1'b0), ctrl_w(5'h16, 5'h01, 1'b0));
    check("main sel", 32'(main_control_select_o), 32'h0000_0016);
    check("sec sel", 32'(secondary_control_select_o), 32'h0000_0001);
    acc(1'b1, `ATCP_ADR_FUNC, 0, 32'h0000_0303);
    acc(1'b1, `ATCP_ADR_VGAIN, 32'h0000_0065, 32'h0000_0014);
    acc(1'b1, `ATCP_ADR_VGAIN, 32'h0000_0064, 32'h0000_0064);
    wb_sel_i <= 4'h1;
    acc(1'b1, `ATCP_ADR_VGAIN, 32'hffff_ff9c, 32'h0000_0064);
    wb_sel_i <= 4'hf;
    acc(1'b1, `ATCP_ADR_TGAIN, 32'h0000_07d1, 32'h0000_0064);
    acc(1'b1, `ATCP_ADR_TGAIN, 32'h0000_07d0, 32'h0000_07d0);
    acc(1'b1, `ATCP_ADR_OFS1, 32'h0000_6aa5, 0);
    acc(1'b1, `ATCP_ADR_OFS1, 32'h0000_6aa4, 32'h0000_6aa4);
    acc(1'b1, `ATCP_ADR_OFS1, 0, 0);
    acc(1'b1, `ATCP_ADR_DB1, 32'h0000_0100, 0);
    acc(1'b1, `ATCP_ADR_DB1, 32'h0000_00ff, 32'h0000_00ff);
    acc(1'b1, `ATCP_ADR_DB2, 32'h0000_00ff, 32'h0000_00ff);
    acc(1'b1, `ATCP_ADR_FILT, 0, 32'h0000_01f4);
    acc(1'b1, `ATCP_ADR_FILT, 32'h0000_3e76, 32'h0000_3e76);
    wb(1'b1, `ATCP_ADR_CTRL, ctrl_w(5'h02, 5'h15, 1'b0));
    repeat (3) @(posedge clk_i);
    sig("run free", run_enable_o, 1'b1);
    wb(1'b1, `ATCP_ADR_CTRL, ctrl_w(5'h05, 5'h15, 1'b0));
    repeat (8) @(posedge clk_i);
    sig("run pin low", run_enable_o, 1'b0);
    digital_in_one_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    sig("run pin high", run_enable_o, 1'b1);
    acc(1'b0, `ATCP_ADR_STAT, 0, 32'h0000_0003);
    wb(1'b1, `ATCP_ADR_CTRL, ctrl_w(5'h03, 5'h15, 1'b0));
    repeat (3) @(posedge clk_i);
    sig("run other", run_enable_o, 1'b0);
    // Jitter stays inside the 255 mV deadband, so the commands must sit at exact zero.
    repeat (24) @(posedge clk_i);
    check("vel zero", 32'(velocity_cmd_o), 0);
    check("trq zero", 32'(torque_cmd_o), 0);
    lvl1 <= 12'hc00;
    lvl2 <= 12'h400;
    gap <= 4'h3;
    repeat (40) @(posedge clk_i);
    sig("vel pos", velocity_cmd_o > 0, 1'b1);
    sig("trq neg", torque_cmd_o < 0, 1'b1);
    wb(1'b1, `ATCP_ADR_FUNC, 32'h0000_0102);
    repeat (40) @(posedge clk_i);
    sig("swap vel neg", velocity_cmd_o < 0, 1'b1);
    sig("swap trq pos", torque_cmd_o > 0, 1'b1);
    wb(1'b1, `ATCP_ADR_CTRL, ctrl_w(5'h03, 5'h15, 1'b1));
    repeat (40) @(posedge clk_i);
    sig("diff trq pos", torque_cmd_o > 0, 1'b1);
    wb(1'b1, `ATCP_ADR_TGAIN, 32'hffff_f830);
    repeat (40) @(posedge clk_i);
    sig("neg gain", torque_cmd_o < 0, 1'b1);
    jit <= 1'b0;
    gap <= 4'h0;
    lvl1 <= 12'h810;
    lvl2 <= 12'h808;
    wb(1'b1, `ATCP_ADR_CTRL, ctrl_w(5'h03, 5'h15, 1'b0) | 32'h0000_0002);
    repeat (4) @(posedge clk_i);
    acc(1'b0, `ATCP_ADR_OFS1, 0, ofs_c(32'h0000_0010));
    acc(1'b0, `ATCP_ADR_OFS2, 0, ofs_c(32'h0000_0008));
    complete_run();
  end
endmodule : testbench
